/* File: common/hop_pkg.sv */
// hop trigger control: shared constants, register map and states
// assumes a 32-bit apb slave at 200 MHz pclk
package hop_pkg;
  localparam int ADDR_W = 11;
  localparam int SEQ_PULSE_NS = 1000;
  localparam int CLK_NS = 5;
  localparam int SEQ_PULSE_CYC = (SEQ_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GEN_BLANK_NS = 1000;
  localparam int GEN_BLANK_CYC = (GEN_BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_GEN_ADDR = 8'h08;
  localparam logic [7:0] OFF_ANA_ADDR = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam int CTRL_SRC_INT = 0;
  localparam int CTRL_GEN_HOP = 1;
  localparam int CTRL_GEN_ARM = 2;
  localparam int CTRL_ANA_HOP = 3;
  localparam int CTRL_ANA_ARM = 4;
  localparam int CTRL_PULSE_EN = 5;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ARMED = 2'b01
  } seq_state_e;
endpackage

/* File: common/trig_sync_if.sv */
// synchronised trigger samples passed from the sync stage to the core
// assumes one pclk domain
`timescale 1ns/1ps
interface trig_sync_if;
  logic       ana_rise;
  logic       gen_rise;
  logic       seq_rise;
  logic       rst_low;
  logic       inhibit_low;
  modport src (output ana_rise, output gen_rise, output seq_rise, output rst_low,
               output inhibit_low);
  modport dst (input ana_rise, input gen_rise, input seq_rise, input rst_low,
               input inhibit_low);
endinterface

/* File: rtl/hop_trigger_ctrl.sv */
// hop trigger control: external/internal hop addressing with apb control
// assumes apb master on pclk; rear-panel pins asynchronous ttl
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module hop_trigger_ctrl
  import hop_pkg::*;
#(
  parameter int AW = ADDR_W
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          analyzer_hop_trig,
  input  wire logic          generator_hop_trig,
  input  wire logic          sequence_hop_trig,
  input  wire logic          seq_addr_reset_n,
  input  wire logic          hop_suppress_n,
  input  wire logic [AW-1:0] hop_table_addr,
  output logic               seq_trig_out,
  output logic               gen_level_off,
  output logic               gen_retune,
  output logic               ana_retune,
  output logic      [AW-1:0] gen_tune_addr,
  output logic      [AW-1:0] ana_tune_addr
);
  trig_sync_if ts ();
  logic [AW-1:0] addr_m_reg;
  logic [AW-1:0] addr_s_reg;

  trig_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    ({hop_suppress_n, seq_addr_reset_n, sequence_hop_trig,
               generator_hop_trig, analyzer_hop_trig}),
    .ts      (ts)
  );

  // address bus: two flops, then sampled alongside the delayed edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_m_reg <= ADDR_ZERO;
      addr_s_reg <= ADDR_ZERO;
    end else begin
      addr_m_reg <= hop_table_addr;
      addr_s_reg <= addr_m_reg;
    end
  end

  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [AW-1:0]     seq_addr_reg, seq_addr_next;
  logic [AW-1:0]     gen_addr_reg, gen_addr_next;
  logic [AW-1:0]     ana_addr_reg, ana_addr_next;
  seq_state_e        pend_reg, pend_next;
  logic [7:0]        pulse_cnt_reg, pulse_cnt_next;
  logic [7:0]        blank_cnt_reg, blank_cnt_next;
  logic              gen_rt_reg, gen_rt_next;
  logic              ana_rt_reg, ana_rt_next;
  logic [15:0]       count_reg, count_next;
  logic [31:0]       prdata_reg, prdata_next;

  logic src_int, gen_on, ana_on, wr, rd, ext_gen, ext_ana, seq_go, do_reset, nonseq;

  always_comb begin
    src_int  = ctrl_reg[CTRL_SRC_INT];
    gen_on   = ctrl_reg[CTRL_GEN_HOP] & ctrl_reg[CTRL_GEN_ARM];
    ana_on   = ctrl_reg[CTRL_ANA_HOP] & ctrl_reg[CTRL_ANA_ARM];
    ext_gen  = ts.gen_rise & ~src_int & gen_on;
    ext_ana  = ts.ana_rise & ~src_int & ana_on;
    seq_go   = ts.seq_rise & src_int;
    do_reset = seq_go & (pend_reg == SEQ_ARMED);
    // a jump from the table top to zero is also non-sequential
    nonseq   = do_reset | (seq_addr_reg == '1);
    wr = psel & penable & pwrite;
    rd = psel & ~penable & ~pwrite;
  end

  always_comb begin
    ctrl_next      = ctrl_reg;
    seq_addr_next  = seq_addr_reg;
    gen_addr_next  = gen_addr_reg;
    ana_addr_next  = ana_addr_reg;
    pend_next      = pend_reg;
    pulse_cnt_next = (pulse_cnt_reg != 8'h00) ? pulse_cnt_reg - 8'h01 : 8'h00;
    blank_cnt_next = (blank_cnt_reg != 8'h00) ? blank_cnt_reg - 8'h01 : 8'h00;
    gen_rt_next    = 1'b0;
    ana_rt_next    = 1'b0;
    count_next     = count_reg;
    prdata_next    = prdata_reg;
    // reset request latched at any time, consumed at the next sequence edge
    if (ts.rst_low) begin
      pend_next = SEQ_ARMED;
    end else if (do_reset) begin
      pend_next = SEQ_IDLE;
    end
    if (ext_gen) begin
      gen_addr_next = addr_s_reg;
      gen_rt_next   = 1'b1;
    end
    if (ext_ana) begin
      ana_addr_next = addr_s_reg;
      ana_rt_next   = 1'b1;
    end
    if (seq_go) begin
      count_next = count_reg + 16'h0001;
      if (do_reset) begin
        seq_addr_next = ADDR_ZERO;
      end else begin
        seq_addr_next = seq_addr_reg + ADDR_ONE;
      end
      if (!ts.inhibit_low) begin
        if (gen_on) begin
          gen_addr_next = seq_addr_next;
          gen_rt_next   = 1'b1;
        end
        if (ana_on) begin
          ana_addr_next = seq_addr_next;
          ana_rt_next   = 1'b1;
        end
      end
      if (nonseq) begin
        pulse_cnt_next = 8'(SEQ_PULSE_CYC);
      end
    end
    if (ctrl_reg[CTRL_PULSE_EN] && gen_on && (ext_gen || (seq_go && !ts.inhibit_low))) begin
      blank_cnt_next = 8'(GEN_BLANK_CYC);
    end
    if (wr && paddr == OFF_CTRL) begin
      ctrl_next = pwdata[CTRL_W-1:0];
    end
    if (rd) begin
      unique case (paddr)
        OFF_CTRL:     prdata_next = {26'h0, ctrl_reg};
        OFF_STATUS:   prdata_next = {16'h0, 5'h0, seq_addr_reg};
        OFF_GEN_ADDR: prdata_next = {21'h0, gen_addr_reg};
        OFF_ANA_ADDR: prdata_next = {21'h0, ana_addr_reg};
        OFF_COUNT:    prdata_next = {16'h0, count_reg};
        default:      prdata_next = BUS_ZERO;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= CTRL_RST;
      seq_addr_reg  <= ADDR_ZERO;
      gen_addr_reg  <= ADDR_ZERO;
      ana_addr_reg  <= ADDR_ZERO;
      pend_reg      <= SEQ_IDLE;
      pulse_cnt_reg <= 8'h00;
      blank_cnt_reg <= 8'h00;
      gen_rt_reg    <= 1'b0;
      ana_rt_reg    <= 1'b0;
      count_reg     <= 16'h0000;
      prdata_reg    <= BUS_ZERO;
    end else begin
      ctrl_reg      <= ctrl_next;
      seq_addr_reg  <= seq_addr_next;
      gen_addr_reg  <= gen_addr_next;
      ana_addr_reg  <= ana_addr_next;
      pend_reg      <= pend_next;
      pulse_cnt_reg <= pulse_cnt_next;
      blank_cnt_reg <= blank_cnt_next;
      gen_rt_reg    <= gen_rt_next;
      ana_rt_reg    <= ana_rt_next;
      count_reg     <= count_next;
      prdata_reg    <= prdata_next;
    end
  end

  assign pready        = 1'b1;
  assign pslverr       = 1'b0;
  assign prdata        = prdata_reg;
  assign seq_trig_out  = (pulse_cnt_reg != 8'h00);
  assign gen_level_off = (blank_cnt_reg != 8'h00);
  assign gen_retune    = gen_rt_reg;
  assign ana_retune    = ana_rt_reg;
  assign gen_tune_addr = gen_addr_reg;
  assign ana_tune_addr = ana_addr_reg;

  sequence s_seq_edge;
    ts.seq_rise && src_int;
  endsequence
  sequence s_reset_pending;
    pend_reg == SEQ_ARMED;
  endsequence
  sequence s_no_reset;
    pend_reg != SEQ_ARMED;
  endsequence

  AST_RESET_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (s_seq_edge and s_reset_pending) |=> seq_addr_reg == ADDR_ZERO)
    else $error("sequence reset did not clear address");
  AST_RESET_ONLY_ON_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    !ts.seq_rise |=> $stable(seq_addr_reg))
    else $error("sequence address moved without edge");
  AST_ANA_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    (ts.ana_rise && (src_int || !ana_on) && !ts.seq_rise) |=> !ana_rt_reg)
    else $error("analyzer retuned while not enabled");
  AST_GEN_EXT: assert property (@(posedge pclk) disable iff (!presetn)
    (ts.gen_rise && !src_int && gen_on) |=> gen_rt_reg && gen_addr_reg == $past(addr_s_reg))
    else $error("generator external hop not taken");
  AST_BLANK: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_gen && ctrl_reg[CTRL_PULSE_EN]) |=> gen_level_off [*8])
    else $error("generator level not pulsed off");
  AST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (s_seq_edge and s_no_reset) |=> seq_addr_reg == $past(seq_addr_reg) + ADDR_ONE)
    else $error("sequence address did not step");
  AST_SEQ_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    (s_seq_edge and s_reset_pending) |=> seq_trig_out [*8])
    else $error("sequence output pulse missing");
  AST_INHIBIT: assert property (@(posedge pclk) disable iff (!presetn)
    (s_seq_edge and ts.inhibit_low) ##0 !ext_gen |=> !gen_rt_reg)
    else $error("hop taken while suppressed");
  AST_EDGE_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
    ts.seq_rise |-> $past(sequence_hop_trig, 2) ##1 !ts.seq_rise)
    else $error("edge detector held high");
endmodule

/* File: rtl/trig_sync.sv */
// two-flop synchronisers for rear-panel inputs; rising edge detection for the ana, gen and seq triggers, levels for reset_n and suppress_n
// assumes asynchronous ttl inputs, pclk domain
`timescale 1ns/1ps
module trig_sync
  import hop_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic [4:0] pins,
  trig_sync_if.src  ts
);
  // bit order: ana, gen, seq, reset_n, suppress_n
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic [4:0] prev_reg;
  logic [4:0] meta_next;
  logic [4:0] sync_next;
  logic [4:0] prev_next;

  always_comb begin
    meta_next = pins;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // idle level for the active-low inputs is high, so reset to high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 5'h18;
      sync_reg <= 5'h18;
      prev_reg <= 5'h18;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign ts.ana_rise    = sync_reg[0] & ~prev_reg[0];
  assign ts.gen_rise    = sync_reg[1] & ~prev_reg[1];
  assign ts.seq_rise    = sync_reg[2] & ~prev_reg[2];
  assign ts.rst_low     = ~sync_reg[3];
  assign ts.inhibit_low = ~sync_reg[4];
endmodule

/* File: verification/hop_ctrl_model.sv */
// far-side hop sequencer: drives rear-panel triggers, address, reset, suppress
// assumes pclk from the bench; pulses and spacing of 1us (200 cycles)
`timescale 1ns/1ps
module hop_ctrl_model
  import hop_pkg::*;
(
  input  wire logic        pclk,
  output logic             ana_trig,
  output logic             gen_trig,
  output logic             seq_trig,
  output logic             reset_n,
  output logic             suppress_n,
  output logic [ADDR_W-1:0] addr
);
  initial begin
    ana_trig = 0;
    gen_trig = 0;
    seq_trig = 0;
    reset_n = 1;
    suppress_n = 1;
    addr = '0;
  end
  task automatic hop(input int kind, input logic [ADDR_W-1:0] a);
    @(posedge pclk);
    addr <= a;
    repeat (200) @(posedge pclk);
    if (kind == 0) ana_trig <= 1;
    else if (kind == 1) gen_trig <= 1;
    else seq_trig <= 1;
    repeat (200) @(posedge pclk);
    ana_trig <= 0;
    gen_trig <= 0;
    seq_trig <= 0;
    repeat (200) @(posedge pclk);
    // hold time over: lines no longer carry the old value
    addr <= ~a;
  endtask
  task automatic req_reset();
    @(posedge pclk);
    reset_n <= 0;
    repeat (200) @(posedge pclk);
    reset_n <= 1;
    repeat (200) @(posedge pclk);
  endtask
  task automatic suppress(input logic v);
    @(posedge pclk);
    suppress_n <= ~v;
  endtask
endmodule

/* File: verification/tb.sv */
// self-checking bench for the hop trigger controller
// assumes the far-side model drives all rear-panel pins
`timescale 1ns/1ps
module tb;
  import hop_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              at, gt, st, rn, sn, so_o, lvl, g_rt, a_rt;
  logic [ADDR_W-1:0] ha, g_ad, a_ad;
  int fail_count = 0;
  int check_count = 0;
  int gr = 0, ar = 0, lo = 0, so = 0, g0, a0, l0, s0;
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (g_rt === 1'b1) gr++;
    if (a_rt === 1'b1) ar++;
    if (lvl === 1'b1) lo++;
    if (so_o === 1'b1) so++;
  end
  hop_ctrl_model m (.pclk(pclk), .ana_trig(at), .gen_trig(gt), .seq_trig(st),
    .reset_n(rn), .suppress_n(sn), .addr(ha));
  hop_trigger_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analyzer_hop_trig(at), .generator_hop_trig(gt), .sequence_hop_trig(st),
    .seq_addr_reset_n(rn), .hop_suppress_n(sn), .hop_table_addr(ha),
    .seq_trig_out(so_o), .gen_level_off(lvl), .gen_retune(g_rt),
    .ana_retune(a_rt), .gen_tune_addr(g_ad), .ana_tune_addr(a_ad));
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      test_done();
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic mark();
    g0 = gr;
    a0 = ar;
    l0 = lo;
    s0 = so;
  endtask
  task automatic scen_ext(input int k, input logic [31:0] on, off,
                          input logic [ADDR_W-1:0] a);
    apb(1, OFF_CTRL, on);
    mark();
    m.hop(k, a);
    chk(k ? gr - g0 : ar - a0, 1);
    chk(32'(k ? g_ad : a_ad), 32'(a));
    chk(lo - l0, on[CTRL_PULSE_EN] ? GEN_BLANK_CYC : 0);
    apb(0, k ? OFF_GEN_ADDR : OFF_ANA_ADDR, 0);
    chk(rd, 32'(a));
    apb(1, OFF_CTRL, off);
    m.hop(k, ~a);
    chk(gr - g0 + ar - a0, 1);
  endtask
  task automatic scen_seq();
    apb(1, OFF_CTRL, 32'h3f);
    mark();
    m.hop(2, 11'h155);
    m.hop(2, 11'h2aa);
    apb(0, OFF_STATUS, 0);
    chk(rd, 32'd2);
    apb(0, OFF_COUNT, 0);
    chk(rd, 32'd2);
    chk(gr - g0 + ar - a0, 4);
    chk(32'(g_ad), 32'd2);
    chk(lo - l0, 2 * GEN_BLANK_CYC);
    chk(so - s0, 0);
    m.hop(1, 11'h0aa);
    chk(gr - g0, 2);
  endtask
  task automatic scen_suppress();
    mark();
    m.suppress(1);
    m.hop(2, 11'h155);
    m.suppress(0);
    apb(0, OFF_STATUS, 0);
    chk(rd, 32'd3);
    chk(gr - g0 + ar - a0, 0);
  endtask
  task automatic scen_reset();
    mark();
    m.req_reset();
    // pending only: nothing moves until the next sequence edge
    apb(0, OFF_STATUS, 0);
    chk(rd, 32'd3);
    chk(so - s0, 0);
    m.hop(2, 11'h155);
    apb(0, OFF_STATUS, 0);
    chk(rd, 32'd0);
    chk(so - s0, SEQ_PULSE_CYC);
  endtask
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, OFF_CTRL, 0);
    chk(rd, 32'(CTRL_RST));
    apb(0, 8'h40, 0);
    chk(rd, BUS_ZERO);
    chk(32'(pslverr), BUS_ZERO);
    scen_ext(1, 32'h26, 32'h22, 11'h5a3);
    scen_ext(0, 32'h18, 32'h08, 11'h7ff);
    scen_seq();
    scen_suppress();
    scen_reset();
    test_done();
  end
endmodule
